// ==== rtl/rx_ring_map.svh ====
// Register offsets, reset values and field positions of the receive ring pointer block.
`ifndef RX_RING_MAP_SVH
`define RX_RING_MAP_SVH
`define RING_START_OFS 8'h00
`define RING_STOP_OFS 8'h04
`define RING_BNDRY_OFS 8'h08
`define RX_CUR_OFS 8'h0C
`define LDMA_LOW_OFS 8'h10
`define LDMA_HIGH_OFS 8'h14
`define FRAMES_LOST_OFS 8'h18
`define RX_STATUS_OFS 8'h1C
`define RING_START_RST 8'h40
`define RING_STOP_RST 8'h80
`define RING_BNDRY_RST 8'h40
`define RX_CUR_RST 8'h40
`define TALLY_MAX 8'hC0
`define ST_ACTIVE_BIT 0
`define ST_ABORT_BIT 1
`endif

// ==== rtl/rx_ring_pkg.sv ====
// Types shared by the receive ring pointer block.
package rx_ring_pkg;
  typedef enum logic [1:0] {
    rx_idle,
    rx_active,
    rx_abort
  } rx_state_t;
endpackage : rx_ring_pkg

// ==== rtl/rx_ring_dma.sv ====
// Receive ring buffer pointer logic with an AHB-Lite register slave.
//
// Behaviour
// - Ring start and stop registers supply only address bits 15 to 8.
// - Each buffer is a 256-byte page; low address byte starts at zero.
// - On each page link the next page is compared with the boundary register.
// - A next page equal to the boundary aborts the receive DMA.
// - Current page register holds the first page of the next packet.
// - A receive error restores the DMA pointer from the current page register.
// - Local DMA address readable as high byte and low byte registers.
// - Every register is accessed as an 8-bit register.
// - A packet lost for lack of pages increments the frames-lost tally.
`timescale 1ns/100ps
`include "rx_ring_map.svh"
module rx_ring_dma
  import rx_ring_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Receive data path.
  input wire logic pkt_start,
  input wire logic byte_wr,
  input wire logic pkt_good,
  input wire logic pkt_error,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_we,
  output logic rx_abort_o
);

  // The pointer is one page byte and one offset byte, so only a 16-bit address fits.
  if (ADDR_W != 16) begin : g_width_check
    $error("ADDR_W must be 16.");
  end

  logic [7:0] start_q;
  logic [7:0] stop_q;
  logic [7:0] bndry_q;
  logic [7:0] cur_q;
  logic [7:0] page_q;
  logic [7:0] low_q;
  logic [7:0] tally_q;
  rx_state_t state_q;
  rx_state_t state_d;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr_q;
  logic rd_pend_q;

  // Bus decode.
  wire addr_ph = hsel && htrans[1] && hready;
  wire wr_take = addr_ph && hwrite;
  wire rd_take = addr_ph && !hwrite;
  wire [7:0] wdata = hwdata[7:0];
  wire wr_start = wr_pend_q && (wr_addr_q == `RING_START_OFS);
  wire wr_stop = wr_pend_q && (wr_addr_q == `RING_STOP_OFS);
  wire wr_bndry = wr_pend_q && (wr_addr_q == `RING_BNDRY_OFS);
  wire wr_cur = wr_pend_q && (wr_addr_q == `RX_CUR_OFS);
  wire rd_tally = rd_pend_q && (rd_addr_q == `FRAMES_LOST_OFS);

  // Page linking: wrap at ring stop, then check against boundary.
  wire page_end = byte_wr && (state_q == rx_active) && (low_q == 8'hFF);
  wire [7:0] page_inc = page_q + 8'h01;
  wire [7:0] next_page = (page_inc == stop_q) ? start_q : page_inc;
  wire hit_bndry = page_end && (next_page == bndry_q);
  wire no_room = pkt_start && (state_q == rx_idle) && (cur_q == bndry_q);
  wire lost = hit_bndry || no_room;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rx_idle: if (pkt_start && !no_room) state_d = rx_active;
      rx_active: begin
        if (hit_bndry) begin
          state_d = rx_abort;
        end else if (pkt_error || pkt_good) begin
          state_d = rx_idle;
        end
      end
      rx_abort: state_d = rx_idle;
      default: state_d = rx_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= rx_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // Ring registers, written by software; only page bits are held.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= `RING_START_RST;
      stop_q <= `RING_STOP_RST;
      bndry_q <= `RING_BNDRY_RST;
    end else begin
      if (wr_start) start_q <= wdata;
      if (wr_stop) stop_q <= wdata;
      if (wr_bndry) bndry_q <= wdata;
    end
  end

  // Current page is loaded by a software write, and otherwise advances only when a packet completes good.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_q <= `RX_CUR_RST;
    end else if (wr_cur) begin
      cur_q <= wdata;
    end else if ((state_q == rx_active) && pkt_good && !pkt_error && !hit_bndry) begin
      cur_q <= page_end ? next_page : ((low_q == 8'h00) ? page_q : next_page);
    end
  end

  // Local DMA pointer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_q <= `RX_CUR_RST;
      low_q <= 8'h00;
    end else if (state_q == rx_idle) begin
      page_q <= wr_cur ? wdata : cur_q;
      low_q <= 8'h00;
    end else if (pkt_error || hit_bndry) begin
      page_q <= cur_q;
      low_q <= 8'h00;
    end else if (byte_wr && (state_q == rx_active)) begin
      low_q <= low_q + 8'h01;
      if (page_end) page_q <= next_page;
    end
  end

  // Frames-lost tally, saturating, cleared on read; a loss in the same cycle as the clear loads one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tally_q <= 8'h00;
    end else if (lost && (rd_tally || tally_q != `TALLY_MAX)) begin
      tally_q <= rd_tally ? 8'h01 : tally_q + 8'h01;
    end else if (rd_tally) begin
      tally_q <= 8'h00;
    end
  end

  // Bus pipeline registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_take;
      rd_pend_q <= rd_take;
      if (addr_ph) wr_addr_q <= haddr;
      if (addr_ph) rd_addr_q <= haddr;
    end
  end

  // Read data registered one cycle after the address phase.
  wire [7:0] status = {6'h00, state_q == rx_abort, state_q == rx_active};
  wire [7:0] rd_mux =
    (haddr == `RING_START_OFS) ? start_q :
    (haddr == `RING_STOP_OFS) ? stop_q :
    (haddr == `RING_BNDRY_OFS) ? bndry_q :
    (haddr == `RX_CUR_OFS) ? cur_q :
    (haddr == `LDMA_LOW_OFS) ? low_q :
    (haddr == `LDMA_HIGH_OFS) ? page_q :
    (haddr == `FRAMES_LOST_OFS) ? tally_q :
    (haddr == `RX_STATUS_OFS) ? status : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= {24'h00_0000, rd_mux};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem_addr = {page_q, low_q};
  assign mem_we = byte_wr && (state_q == rx_active);
  assign rx_abort_o = hit_bndry;

  // Assertions.
  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
      page_end && !hit_bndry && !pkt_error && (page_q + 8'h01 == stop_q)
      |=> page_q == $past(start_q);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Page did not wrap to ring start.");

  property p_abort;
    @(posedge hclk) disable iff (!hresetn)
      hit_bndry |=> (state_q == rx_abort) && (page_q == $past(cur_q));
  endproperty
  a_abort: assert property (p_abort) else $error("Boundary hit did not abort.");

  property p_restore;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == rx_active) && pkt_error |=> page_q == $past(cur_q) && low_q == 8'h00;
  endproperty
  a_restore: assert property (p_restore) else $error("Error did not restore pointer.");

  property p_low_inc;
    @(posedge hclk) disable iff (!hresetn)
      mem_we && !pkt_error && !hit_bndry |=> low_q == $past(low_q) + 8'h01;
  endproperty
  a_low_inc: assert property (p_low_inc) else $error("Low byte did not step.");

  property p_new_page_low;
    @(posedge hclk) disable iff (!hresetn)
      page_end |=> low_q == 8'h00;
  endproperty
  a_new_page_low: assert property (p_new_page_low) else $error("Page start not zero.");

  property p_tally;
    @(posedge hclk) disable iff (!hresetn)
      lost && !rd_tally && tally_q < `TALLY_MAX |=> tally_q == $past(tally_q) + 8'h01;
  endproperty
  a_tally: assert property (p_tally) else $error("Frames lost tally missed.");

  property p_start_wr;
    @(posedge hclk) disable iff (!hresetn)
      wr_start |=> start_q == $past(hwdata[7:0]);
  endproperty
  a_start_wr: assert property (p_start_wr) else $error("Ring start write lost.");

  property p_cmp;
    @(posedge hclk) disable iff (!hresetn)
      page_end && (next_page != bndry_q) && !pkt_error && !pkt_good |=> state_q == rx_active;
  endproperty
  a_cmp: assert property (p_cmp) else $error("Abort without boundary match.");

  property p_read;
    @(posedge hclk) disable iff (!hresetn)
      rd_take && haddr == `LDMA_HIGH_OFS |=> hrdata == {24'h00_0000, $past(page_q)};
  endproperty
  a_read: assert property (p_read) else $error("High address readback wrong.");

  property p_cur_good;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == rx_active) && pkt_good && !pkt_error && !wr_cur && !page_end
      && low_q != 8'h00 |=> cur_q == $past(next_page);
  endproperty
  a_cur_good: assert property (p_cur_good) else $error("Current page not advanced.");

  property p_abort_one;
    @(posedge hclk) disable iff (!hresetn)
      state_q == rx_abort |=> state_q == rx_idle;
  endproperty
  a_abort_one: assert property (p_abort_one) else $error("Abort state held too long.");

  property p_no_room;
    @(posedge hclk) disable iff (!hresetn)
      no_room |=> state_q == rx_idle;
  endproperty
  a_no_room: assert property (p_no_room) else $error("Packet taken without room.");

  property p_idle_zero;
    @(posedge hclk) disable iff (!hresetn)
      state_q == rx_idle |=> low_q == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("Low byte not zero when idle.");

  property p_cur_hold;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == rx_active) && !pkt_good && !wr_cur |=> $stable(cur_q);
  endproperty
  a_cur_hold: assert property (p_cur_hold) else $error("Current page moved mid packet.");

  property p_page_step;
    @(posedge hclk) disable iff (!hresetn)
      page_end && !hit_bndry && !pkt_error |=> page_q == $past(next_page);
  endproperty
  a_page_step: assert property (p_page_step) else $error("Page did not link.");

  property p_byte_wide;
    @(posedge hclk) disable iff (!hresetn)
      rd_take |=> hrdata[31:8] == 24'h00_0000;
  endproperty
  a_byte_wide: assert property (p_byte_wide) else $error("Read data wider than a byte.");

  property p_tally_sat;
    @(posedge hclk) disable iff (!hresetn)
      tally_q <= `TALLY_MAX;
  endproperty
  a_tally_sat: assert property (p_tally_sat) else $error("Frames lost tally overran.");

  c_wrap: cover property (@(posedge hclk) page_end && page_inc == stop_q);
  c_abort: cover property (@(posedge hclk) hit_bndry);
  c_err: cover property (@(posedge hclk) state_q == rx_active && pkt_error);
  c_lost: cover property (@(posedge hclk) no_room);

endmodule : rx_ring_dma

// ==== dv/rx_buf_mem.sv ====
// Buffer memory model that records where the receive DMA writes.
`timescale 1ns/100ps
module rx_buf_mem (
  // Clock.
  input wire logic hclk,
  // Write port from the DMA.
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  // Observation.
  output logic [15:0] last_addr
);
  initial last_addr = 16'h0000;
  always @(posedge hclk) begin
    if (mem_we === 1'b1) begin
      last_addr <= mem_addr;
    end
  end
endmodule : rx_buf_mem

// ==== dv/receive_ring_buffer_pointers_tb.sv ====
// Self-checking bench for the receive ring pointer block.
`timescale 1ns/100ps
`include "rx_ring_map.svh"
module receive_ring_buffer_pointers_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic pkt_start = 0, byte_wr = 0, pkt_good = 0, pkt_error = 0, rd_dph = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rnd = 32'h0000_0d20;
  logic [31:0] expq[$];
  wire logic [31:0] hrdata;
  wire logic [15:0] mem_addr, last_addr;
  wire logic hreadyout, hresp, mem_we, rx_abort_o;
  int n_errors = 0, comparisons = 0, n_abort = 0, n;

  rx_ring_dma dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pkt_start(pkt_start),
    .byte_wr(byte_wr), .pkt_good(pkt_good), .pkt_error(pkt_error), .mem_addr(mem_addr),
    .mem_we(mem_we), .rx_abort_o(rx_abort_o));
  rx_buf_mem mem (.hclk(hclk), .mem_addr(mem_addr), .mem_we(mem_we), .last_addr(last_addr));

  initial begin
    forever #12.5 hclk = ~hclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic conclude;
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // One single AHB transfer; a read notes its expected data in the queue.
  task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d);
    if (!w) expq.push_back({24'h00_0000, d});
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {rnd[23:0], d};
    rnd = lfsr(rnd);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : bus

  // One packet of nb bytes, ended good (1), in error (2) or not at all (0).
  task automatic pkt(input int nb, input int endk);
    @(posedge hclk) pkt_start <= 1'b1;
    @(posedge hclk);
    pkt_start <= 1'b0;
    byte_wr <= 1'b1;
    repeat (nb) @(posedge hclk);
    byte_wr <= 1'b0;
    pkt_good <= (endk == 1);
    pkt_error <= (endk == 2);
    @(posedge hclk);
    pkt_good <= 1'b0;
    pkt_error <= 1'b0;
  endtask : pkt

  always @(posedge hclk) begin
    if (rx_abort_o === 1'b1) n_abort++;
    if (hreadyout === 1'b1) begin
      if (rd_dph) chk("hrdata", expq.pop_front(), hrdata);
      rd_dph <= hsel & htrans[1] & !hwrite;
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `RING_START_OFS, 8'h40);
    bus(0, `RING_STOP_OFS, 8'h80);
    bus(0, `RING_BNDRY_OFS, 8'h40);
    bus(0, `RX_CUR_OFS, 8'h40);
    bus(0, `LDMA_HIGH_OFS, 8'h40);
    bus(1, `LDMA_LOW_OFS, 8'hFF);
    bus(0, `LDMA_LOW_OFS, 8'h00);
    bus(0, 8'h20, 8'h00);
    bus(1, `RING_START_OFS, 8'h10);
    bus(1, `RING_STOP_OFS, 8'h14);
    bus(1, `RING_BNDRY_OFS, 8'h12);
    bus(1, `RX_CUR_OFS, 8'h10);
    n = int'(rnd[6:0]) + 1;
    pkt(n, 1);
    bus(0, `LDMA_LOW_OFS, 8'h00);
    bus(0, `LDMA_HIGH_OFS, 8'h11);
    chk("last_addr", 32'h0000_1000 + n - 1, 32'(last_addr));
    bus(0, `RX_CUR_OFS, 8'h11);
    pkt(256, 0);
    chk("abort", 1, n_abort);
    bus(0, `LDMA_HIGH_OFS, 8'h11);
    bus(0, `LDMA_LOW_OFS, 8'h00);
    bus(1, `RING_BNDRY_OFS, 8'h11);
    pkt(1, 1);
    bus(0, `FRAMES_LOST_OFS, 8'h02);
    bus(0, `FRAMES_LOST_OFS, 8'h00);
    bus(1, `RING_BNDRY_OFS, 8'h10);
    pkt(768, 0);
    chk("abort", 2, n_abort);
    pkt(300, 2);
    bus(0, `LDMA_HIGH_OFS, 8'h11);
    bus(0, `LDMA_LOW_OFS, 8'h00);
    bus(0, `RX_CUR_OFS, 8'h11);
    bus(1, `RING_BNDRY_OFS, 8'h20);
    pkt(778, 1);
    chk("last_addr", 32'h0000_1009, 32'(last_addr));
    chk("abort", 2, n_abort);
    bus(0, `RX_CUR_OFS, 8'h11);
    conclude();
  end
endmodule : receive_ring_buffer_pointers_tb
